// ---- design/iss_map.svh ----
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 125 MHz aclk, AXI4-Lite word access
// Notes: Speeds are r/min, times are ms
// How it works
// - Feature bit enables the three select inputs
// - Select pair chooses preset one, two, three
// - Direction input off forward, on reverse
// - No select: decelerate, then enter hold state
// - Never applied under torque control
// - Two-bit stop mode decoded from setup one
// - Servo-lock holds zero command, position loop off
// - Position-lock engages below lock speed threshold
// - Internal-only modes ignore analog speed command
// - Combined modes accept analog when selects off
// - Analog followed at once, no lock wait
// - Accel time 0 to 10000 ms, default 0
// - Decel time 0 to 10000 ms, default 0
// - Ramp time scales with speed, constant slope
// - Ramp applies to presets and analog command
// - Three presets, defaults 100, 200, 300
// - Lock speed threshold, default 10 r/min
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH
`define ISS_OFS_SETUP_ONE 6'h00
`define ISS_OFS_SETUP_TWO 6'h04
`define ISS_OFS_ACCEL 6'h08
`define ISS_OFS_DECEL 6'h0C
`define ISS_OFS_LOCK_SPD 6'h10
`define ISS_OFS_PRESET_ONE 6'h14
`define ISS_OFS_PRESET_TWO 6'h18
`define ISS_OFS_PRESET_THREE 6'h1C
`define ISS_OFS_STATUS 6'h20
`define ISS_OFS_SPEED_CMD 6'h24
`define ISS_RST_SETUP 16'h0000
`define ISS_RST_TIME 16'h0000
`define ISS_RST_LOCK_SPD 16'h000A
`define ISS_RST_PRESET_ONE 16'h0064
`define ISS_RST_PRESET_TWO 16'h00C8
`define ISS_RST_PRESET_THREE 16'h012C
`define ISS_BIT_TORQUE_MODE 0
`define ISS_BIT_STOP_LOCK 10
`define ISS_BIT_STOP_COMBINED 11
`define ISS_BIT_FEATURE_EN 2
`define ISS_MAX_RPM 16'h1194
`define ISS_MAX_TIME_MS 16'h2710
`define ISS_CLK_PERIOD_NS 8
`define ISS_MS_NS 1000000
`define ISS_CYC_PER_MS (`ISS_MS_NS / `ISS_CLK_PERIOD_NS)
`endif

// ---- design/iss_pkg.sv ----
// Purpose: Types shared by the speed select and ramp logic
// Assumes: Nothing beyond SystemVerilog
// Notes: Speeds are signed r/min
`default_nettype none
package iss_pkg;
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_RUN = 6'h02,
        ST_STOP = 6'h04,
        ST_SLOCK = 6'h08,
        ST_PLOCK = 6'h10,
        ST_ANALOG = 6'h20
    } iss_state_t;

    typedef struct packed {
        logic dir;
        logic sel_two;
        logic sel_one;
    } iss_sel_t;

    function automatic logic [15:0] iss_abs(input logic signed [15:0] v);
        iss_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction
endpackage
`default_nettype wire

// ---- design/iss_sync.sv ----
// Purpose: Two-stage synchroniser for the pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second
`default_nettype none
module iss_sync #(
    parameter int W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_reg[i] <= 1'b0;
                q[i] <= 1'b0;
            end else begin
                meta_reg[i] <= d[i];
                q[i] <= meta_reg[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/iss_ramp.sv ----
// Purpose: Soft-start ramp toward a signed speed target
// Assumes: Times in ms, speeds in r/min
// Notes: Bresenham pacing, one r/min step per tick
`default_nettype none
`include "iss_map.svh"
module iss_ramp #(
    parameter int CYC_PER_MS = `ISS_CYC_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic signed [15:0] target,
    input wire logic [15:0] accel_ms,
    input wire logic [15:0] decel_ms,
    output var logic signed [15:0] cmd_reg
);
    logic [31:0] acc_reg;
    logic toward_zero;
    logic [15:0] time_ms;
    logic [31:0] thr;
    logic [31:0] acc_sum;

    always_comb begin
        toward_zero = (cmd_reg != 16'sh0000) && ((target[15] != cmd_reg[15])
            || (iss_pkg::iss_abs(target) < iss_pkg::iss_abs(cmd_reg)));
        time_ms = toward_zero ? decel_ms : accel_ms;
        // Full scale over the set time keeps the slope fixed
        thr = 32'(time_ms) * 32'(CYC_PER_MS);
        acc_sum = acc_reg + 32'(`ISS_MAX_RPM);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= 16'sh0000;
            acc_reg <= 32'h0000_0000;
        end else if (cmd_reg == target || time_ms == 16'h0000) begin
            cmd_reg <= target;
            acc_reg <= 32'h0000_0000;
        end else if (acc_sum >= thr) begin
            // One step per tick toward the target
            acc_reg <= acc_sum - thr;
            cmd_reg <= (target > cmd_reg) ? cmd_reg + 16'sh0001 : cmd_reg - 16'sh0001;
        end else begin
            acc_reg <= acc_sum;
        end
    end
endmodule
`default_nettype wire

// ---- design/iss_top.sv ----
// Purpose: Internal speed select with soft start and stop hold
// Assumes: Analog command and motor speed come from aclk logic
// Notes: Pins pass a two-stage synchroniser, delay far below 6 ms
//
// Local design decisions: the AXI4-Lite register port and the address map.
`default_nettype none
`include "iss_map.svh"
module iss_top #(
    parameter int CYC_PER_MS = `ISS_CYC_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output var logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output var logic s_axil_wready,
    output var logic [1:0] s_axil_bresp,
    output var logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [5:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output var logic s_axil_arready,
    output var logic [31:0] s_axil_rdata,
    output var logic [1:0] s_axil_rresp,
    output var logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic select_one_input_pin,
    input wire logic select_two_input_pin,
    input wire logic direction_input_pin,
    input wire logic signed [15:0] analog_speed_cmd,
    input wire logic signed [15:0] motor_speed,
    output var logic signed [15:0] speed_cmd,
    output var logic servo_lock,
    output var logic position_lock,
    output var logic position_loop_en,
    output var logic analog_accepted
);
    localparam logic [15:0] RST_VAL [0:7] = '{
        `ISS_RST_SETUP, `ISS_RST_SETUP, `ISS_RST_TIME, `ISS_RST_TIME,
        `ISS_RST_LOCK_SPD, `ISS_RST_PRESET_ONE, `ISS_RST_PRESET_TWO,
        `ISS_RST_PRESET_THREE
    };

    logic [15:0] cfg_reg [0:7];
    iss_pkg::iss_sel_t sel;
    iss_pkg::iss_state_t state_reg;
    iss_pkg::iss_state_t state_next;
    logic signed [15:0] target_reg;
    logic signed [15:0] target_next;
    logic signed [15:0] ramp_cmd;

    logic aw_full_reg;
    logic w_full_reg;
    logic [5:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic aw_full_next;
    logic w_full_next;
    logic bvalid_next;
    logic ar_take;
    logic rvalid_next;
    logic [31:0] rd_data;
    logic rd_ok;

    // Synchronise the three select pins before anything reads them
    iss_sync #(
        .W(3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({direction_input_pin, select_two_input_pin, select_one_input_pin}),
        .q(sel)
    );

    iss_ramp #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_ramp (
        .aclk(aclk),
        .aresetn(aresetn),
        .target(target_reg),
        .accel_ms(cfg_reg[2]),
        .decel_ms(cfg_reg[3]),
        .cmd_reg(ramp_cmd)
    );

    // Configuration fields
    logic torque_mode;
    logic stop_combined;
    logic stop_poslock;
    logic feature_on;
    logic sel_none;
    logic below_lock;
    logic analog_small;
    logic [15:0] preset;

    always_comb begin
        torque_mode = cfg_reg[0][`ISS_BIT_TORQUE_MODE];
        // Bit b picks combined, bit A picks position-lock
        stop_combined = cfg_reg[0][`ISS_BIT_STOP_COMBINED];
        stop_poslock = cfg_reg[0][`ISS_BIT_STOP_LOCK];
        // Speed control only, never torque control
        feature_on = cfg_reg[1][`ISS_BIT_FEATURE_EN] && !torque_mode;
        sel_none = !sel.sel_one && !sel.sel_two;
        // Threshold compares against the motor's own speed and the analog command
        below_lock = iss_pkg::iss_abs(motor_speed) < cfg_reg[4];
        analog_small = iss_pkg::iss_abs(analog_speed_cmd) <= cfg_reg[4];
        // Off/on picks one, on/on two, on/off three
        unique case ({sel.sel_one, sel.sel_two})
            2'b01: preset = cfg_reg[5];
            2'b11: preset = cfg_reg[6];
            default: preset = cfg_reg[7];
        endcase
    end

    // Mode sequencing
    always_comb begin
        state_next = state_reg;
        if (!feature_on) begin
            state_next = iss_pkg::ST_OFF;
        end else if (!sel_none) begin
            state_next = iss_pkg::ST_RUN;
        end else if (stop_combined) begin
            // Analog taken as soon as the selects read off
            unique case (state_reg)
                iss_pkg::ST_PLOCK: begin
                    if (!stop_poslock || !analog_small) begin
                        state_next = iss_pkg::ST_ANALOG;
                    end
                end
                iss_pkg::ST_ANALOG: begin
                    if (stop_poslock && below_lock && analog_small) begin
                        state_next = iss_pkg::ST_PLOCK;
                    end
                end
                default: state_next = iss_pkg::ST_ANALOG;
            endcase
        end else begin
            unique case (state_reg)
                iss_pkg::ST_SLOCK: begin
                    if (stop_poslock) begin
                        state_next = iss_pkg::ST_STOP;
                    end
                end
                iss_pkg::ST_PLOCK: begin
                    if (!stop_poslock) begin
                        state_next = iss_pkg::ST_STOP;
                    end
                end
                iss_pkg::ST_STOP: begin
                    // Servo-lock only after the decel ramp reaches zero; position-lock once the motor is below lock speed
                    if (stop_poslock && below_lock) begin
                        state_next = iss_pkg::ST_PLOCK;
                    end else if (!stop_poslock && ramp_cmd == 16'sh0000) begin
                        state_next = iss_pkg::ST_SLOCK;
                    end
                end
                default: state_next = iss_pkg::ST_STOP;
            endcase
        end
    end

    // Ramp target per mode
    always_comb begin
        unique case (state_next)
            iss_pkg::ST_OFF: begin
                // Plain speed control still ramps the analog input
                target_next = torque_mode ? 16'sh0000 : analog_speed_cmd;
            end
            iss_pkg::ST_RUN: begin
                // Direction on means reverse
                target_next = sel.dir ? -$signed(preset) : $signed(preset);
            end
            iss_pkg::ST_ANALOG: target_next = analog_speed_cmd;
            // Internal-only stops never look at the analog input
            default: target_next = 16'sh0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= iss_pkg::ST_OFF;
            target_reg <= 16'sh0000;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_cmd <= 16'sh0000;
            servo_lock <= 1'b0;
            position_lock <= 1'b0;
            position_loop_en <= 1'b0;
            analog_accepted <= 1'b0;
        end else begin
            // Zero command and no position loop in servo-lock
            speed_cmd <= (state_reg == iss_pkg::ST_SLOCK) ? 16'sh0000 : ramp_cmd;
            servo_lock <= state_next == iss_pkg::ST_SLOCK;
            position_lock <= state_next == iss_pkg::ST_PLOCK;
            position_loop_en <= state_next == iss_pkg::ST_PLOCK;
            analog_accepted <= state_next == iss_pkg::ST_ANALOG
                || state_next == iss_pkg::ST_OFF;
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    always_comb begin
        aw_take = s_axil_awvalid && s_axil_awready;
        w_take = s_axil_wvalid && s_axil_wready;
        do_write = aw_full_reg && w_full_reg && !s_axil_bvalid;
        aw_full_next = (aw_full_reg && !do_write) || aw_take;
        w_full_next = (w_full_reg && !do_write) || w_take;
        bvalid_next = do_write || (s_axil_bvalid && !s_axil_bready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 6'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axil_awready <= 1'b0;
            s_axil_wready <= 1'b0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= 2'b00;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axil_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axil_wdata;
                wstrb_reg <= s_axil_wstrb;
            end
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            s_axil_awready <= !aw_full_next && !bvalid_next;
            s_axil_wready <= !w_full_next && !bvalid_next;
            s_axil_bvalid <= bvalid_next;
            if (do_write) begin
                // Status words are read-only, so writes there are refused too
                s_axil_bresp <= (awaddr_reg < `ISS_OFS_STATUS) ? 2'b00 : 2'b10;
            end
        end
    end

    // Range-limited register storage; out-of-range writes saturate
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    logic [15:0] wr_val;
    logic [2:0] wr_idx;

    always_comb begin
        wr_idx = awaddr_reg[4:2];
        wr_val = cfg_reg[wr_idx];
        if (wstrb_reg[0]) begin
            wr_val[7:0] = wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
            wr_val[15:8] = wdata_reg[15:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                cfg_reg[i] <= RST_VAL[i];
            end
        end else if (do_write && awaddr_reg < `ISS_OFS_STATUS) begin
            unique case (wr_idx)
                3'h0, 3'h1: cfg_reg[wr_idx] <= wr_val;
                // Times capped at 10000 ms
                3'h2, 3'h3: cfg_reg[wr_idx] <= clamp(wr_val, `ISS_MAX_TIME_MS);
                // Speeds capped at 4500 r/min
                default: cfg_reg[wr_idx] <= clamp(wr_val, `ISS_MAX_RPM);
            endcase
        end
    end

    // AXI4-Lite read path, one word per request
    always_comb begin
        ar_take = s_axil_arvalid && s_axil_arready;
        rvalid_next = ar_take || (s_axil_rvalid && !s_axil_rready);
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        if (s_axil_araddr < `ISS_OFS_STATUS) begin
            rd_data = {16'h0000, cfg_reg[s_axil_araddr[4:2]]};
        end else if (s_axil_araddr == `ISS_OFS_STATUS) begin
            rd_data = {23'h000000, state_reg, sel};
        end else if (s_axil_araddr == `ISS_OFS_SPEED_CMD) begin
            rd_data = {16'h0000, ramp_cmd};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= 2'b00;
        end else begin
            s_axil_arready <= !rvalid_next;
            s_axil_rvalid <= rvalid_next;
            if (ar_take) begin
                s_axil_rdata <= rd_data;
                s_axil_rresp <= rd_ok ? 2'b00 : 2'b10;
            end
        end
    end

    // Unused protection bits and upper write data and strobe bits
    logic unused_ok;
    assign unused_ok = ^{s_axil_awprot, s_axil_arprot, wdata_reg[31:16], wstrb_reg[3:2]};
endmodule
`default_nettype wire

// ---- bench/iss_host.sv ----
// Purpose: Host controller model driving the three select pins
// Assumes: Bench requests a pin pattern through want
// Notes: Patterns held HOLD cycles at least
`default_nettype none
module iss_host #(
    parameter int HOLD = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire iss_pkg::iss_sel_t want,
    output var logic sel_one_pin,
    output var logic sel_two_pin,
    output var logic dir_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    iss_pkg::iss_sel_t cur;
    int hold_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= '0;
            hold_cnt <= 0;
        end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end else if (want != cur) begin
            cur <= want;
            hold_cnt <= HOLD;
        end
    end
    assign sel_one_pin = cur.sel_one;
    assign sel_two_pin = cur.sel_two;
    assign dir_pin = cur.dir;
endmodule
`default_nettype wire

// ---- bench/iss_chk_chk.sv ----
// Purpose: Port-level checks for the speed select block
// Assumes: One aclk domain, synchronous active-low reset
// Notes: Mode timing is checked by the bench
`default_nettype none
module iss_chk #(
    parameter int CYC_PER_MS = 125000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic signed [15:0] speed_cmd,
    input wire logic servo_lock,
    input wire logic position_lock,
    input wire logic position_loop_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_both;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence rd_take;
        s_axil_arvalid && s_axil_arready;
    endsequence
    AST_B_LATENCY: assert property (wr_both |-> ##2 s_axil_bvalid)
        else $error("write response not on time");
    AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped");
    AST_B_BLOCK: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
        else $error("write taken while response pending");
    AST_R_LATENCY: assert property (rd_take |=> s_axil_rvalid)
        else $error("read data not on time");
    AST_R_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data dropped");
    AST_R_BLOCK: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read taken while data pending");
    AST_SLOCK_ZERO: assert property (servo_lock |-> speed_cmd == 16'sh0000 && !position_loop_en)
        else $error("servo lock with nonzero command");
    AST_PLOCK_LOOP: assert property (position_lock == position_loop_en)
        else $error("position lock and loop disagree");
    AST_LOCK_EXCL: assert property (!(servo_lock && position_lock))
        else $error("both hold states at once");
endmodule
bind iss_top iss_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rvalid, .s_axil_rready, .speed_cmd, .servo_lock,
    .position_lock, .position_loop_en);
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the speed select block
// Assumes: 1 ms is 10 cycles
// Notes: Ramp windows allow for pin sync latency
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPM = 10;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, p1, p2, pd;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    logic signed [15:0] analog, motor, speed_cmd;
    logic servo_lock, plock, ploop, acc;
    iss_pkg::iss_sel_t want;
    int n_fail, n_tests, r, c;
    logic [15:0] pre [3];
    logic [15:0] rst_tab [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                 16'h000A, 16'h0064, 16'h00C8, 16'h012C};
    logic [1:0] sel_tab [3] = '{2'b10, 2'b11, 2'b01};
    logic signed [15:0] mv [3] = '{16'sh0064, 16'sh000A, 16'sh0009};

    iss_top #(.CYC_PER_MS(CPM)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .select_one_input_pin(p1), .select_two_input_pin(p2),
        .direction_input_pin(pd), .analog_speed_cmd(analog), .motor_speed(motor),
        .speed_cmd(speed_cmd), .servo_lock(servo_lock), .position_lock(plock),
        .position_loop_en(ploop), .analog_accepted(acc));
    iss_host #(.HOLD(8)) u_host (.aclk(aclk), .aresetn(aresetn), .want(want),
        .sel_one_pin(p1), .sel_two_pin(p2), .dir_pin(pd));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        chk("bvalid", 32'(bvalid), 32'h1);
    endtask

    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk("rvalid", 32'(rvalid), 32'h1);
    endtask

    task automatic setp(input logic [2:0] v, input int n);
        want <= v;
        repeat (n) @(posedge aclk);
    endtask

    function automatic logic signed [15:0] exp_spd(input int k, input bit d);
        exp_spd = d ? -$signed(pre[k]) : $signed(pre[k]);
    endfunction

    function automatic int ramp_cyc(input int spd, input int ms);
        ramp_cyc = spd * ms * CPM / 4500;
    endfunction

    task automatic ramp_meas(input logic [2:0] v, input logic signed [15:0] tgt, input int e);
        int k;
        logic ok;
        logic signed [15:0] prv;
        logic signed [16:0] d;
        ok = 1'b1;
        k = 0;
        prv = speed_cmd;
        want <= v;
        while (speed_cmd !== tgt && k < 12000) begin
            @(posedge aclk);
            k++;
            d = speed_cmd - prv;
            ok = ok && d <= 1 && d >= -1;
            prv = speed_cmd;
        end
        chk("ramp_time", 32'(k >= e - 10 && k <= e + 40), 32'h1);
        chk("ramp_step", 32'(ok), 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, want, analog, motor} = '0;
        n_fail = 0;
        n_tests = 0;
        void'($urandom(32'hFE8DB5D8));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            axr(6'(i * 4), rd, resp);
            chk("reset_value", rd, {16'h0000, rst_tab[i]});
        end
        axr(6'h28, rd, resp);
        chk("unmapped_rresp", 32'(resp), 32'h2);
        chk("unmapped_rdata", rd, 32'h0);
        axw(6'h20, 32'h1234, resp);
        chk("ro_bresp", 32'(resp), 32'h2);
        $display("test reset_map done");
        axw(6'h1C, 32'h1388, resp);
        axr(6'h1C, rd, resp);
        chk("preset_sat", rd, 32'h1194);
        axw(6'h08, 32'h3000, resp);
        axr(6'h08, rd, resp);
        chk("time_sat", rd, 32'h2710);
        axw(6'h08, 32'h0, resp);
        for (int i = 0; i < 3; i++) begin
            pre[i] = 16'($urandom_range(4500, 20));
            axw(6'(20 + i * 4), {16'h0, pre[i]}, resp);
            axr(6'(20 + i * 4), rd, resp);
            chk("preset_rw", rd, {16'h0, pre[i]});
        end
        $display("test register_rw done");
        setp(3'b010, 20);
        chk("feature_off", speed_cmd, 16'sh0000);
        axw(6'h04, 32'h4, resp);
        r = $urandom_range(5, 0);
        for (int i = 0; i < 6; i++) begin
            c = (i + r) % 6;
            setp({c >= 3, sel_tab[c % 3]}, 20);
            chk("preset_select", speed_cmd, exp_spd(c % 3, c >= 3));
        end
        $display("test select done");
        analog <= 16'($urandom_range(4000, 100));
        setp(3'b000, 20);
        chk("stop_cmd", speed_cmd, 16'sh0000);
        chk("servo_lock", 32'(servo_lock), 32'h1);
        chk("loop_off", 32'(ploop), 32'h0);
        chk("analog_refused", 32'(acc), 32'h0);
        $display("test servo_stop done");
        setp(3'b010, 20);
        axw(6'h00, 32'h400, resp);
        motor <= mv[0];
        setp(3'b000, 20);
        for (int i = 0; i < 3; i++) begin
            motor <= mv[i];
            repeat (20) @(posedge aclk);
            chk("pos_lock", 32'(plock), 32'(i == 2));
        end
        chk("plock_loop", 32'(ploop), 32'h1);
        chk("plock_cmd", speed_cmd, 16'sh0000);
        $display("test pos_stop done");
        setp(3'b011, 20);
        axw(6'h00, 32'h800, resp);
        for (int i = 0; i < 2; i++) begin
            analog <= 16'(int'($urandom_range(6000, 0)) - 3000);
            setp(3'b000, 10);
            chk("analog_acc", 32'(acc), 32'h1);
            chk("analog_follow", speed_cmd, analog);
            chk("no_lock_wait", 32'(servo_lock), 32'h0);
        end
        axw(6'h00, 32'hC00, resp);
        analog <= 16'sh0003;
        motor <= 16'sh0000;
        repeat (20) @(posedge aclk);
        chk("comb_plock", 32'(plock), 32'h1);
        analog <= 16'sh01F4;
        repeat (20) @(posedge aclk);
        chk("comb_release", 32'(plock), 32'h0);
        chk("comb_follow", speed_cmd, 16'sh01F4);
        $display("test combined done");
        axw(6'h00, 32'h1, resp);
        analog <= 16'sh02BC;
        setp(3'b001, 20);
        chk("torque_mode", speed_cmd, 16'sh0000);
        $display("test torque done");
        setp(3'b000, 20);
        axw(6'h08, 32'h2710, resp);
        axw(6'h0C, 32'h1388, resp);
        axw(6'h14, 32'h1C2, resp);
        axw(6'h00, 32'h0, resp);
        repeat (20) @(posedge aclk);
        ramp_meas(3'b010, 16'sh01C2, ramp_cyc(450, 10000));
        ramp_meas(3'b000, 16'sh0000, ramp_cyc(450, 5000));
        chk("ramp_hold", 32'(servo_lock), 32'h1);
        $display("test ramp done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
